// ==== rtl/gas_zero_ctrl.sv ====
// mode, reporting and zero point control of a gas sensor
//
// Behaviour
// RULE1 - streams twenty reports per second; streaming is factory default
// RULE2 - streaming: commands wait while a measurement runs, up to ten ms
// RULE3 - polling sends a reading only when the host asks
// RULE4 - polling keeps measuring and updating latest result, output held back
// RULE5 - stream or poll choice kept non-volatile and resumed at power-up
// RULE6 - filtered value, smoothed by filter setting, and raw value available
// RULE7 - host picks filter 64, 32, 16 or 8 by flow rate
// RULE8 - each zero replaces the stored zero point, never accumulates; fine adjust here adds to the stored zero instead
// RULE9 - host sets filter to 32 before zeroing
// RULE10 - known-gas zero makes present reading equal supplied scaled value
// RULE11 - nitrogen zero makes present reading equal zero
// RULE12 - fresh-air zero uses stored level, default 400, programmable
// RULE13 - fine adjust shifts zero so reported reading maps to true value
// RULE14 - auto-zero disabled after reset until host enables it
// RULE15 - auto-zero replaces zero using its own target level
// RULE16 - host may enable periodic auto-zero or force one now
// RULE17 - optional first auto-zero after power-on delay, then periodic
// RULE18 - auto-zero enable, interval and level are volatile
// RULE19 - auto-zero level register separate from fresh-air level
// RULE20 - sleep: no measurements, reading and zero commands rejected
// RULE21 - sleep never survives power cycle
// RULE22 - commands end in CR LF; unknown command answered with question mark; here a command is a write to ADR_CMD and an unknown code pulses unknown_o
// RULE23 - command arriving during measurement held and run afterwards; held only in streaming, in polling it runs at once
`timescale 1ns/1ps
`include "gas_zero_params.svh"
module gas_zero_ctrl #(
   parameter int MEAS_CYC      = `MEAS_CYC,
   parameter int MEAS_BUSY_CYC = `MEAS_BUSY_CYC,
   parameter int AZ_TICK_CYC   = `CLK_HZ
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   input  wire logic [15:0] sample_i,
   input  wire logic        nv_poll_i,
   output logic             nv_poll_o,
   output logic             nv_wr_o,
   output logic             report_o,
   output logic      [15:0] report_dat_o,
   output logic             unknown_o
);
   import gas_zero_pkg::*;

   // ****************************************
   // bus slave
   // ****************************************
   logic            acc;
   logic            wr;
   logic            ack_r;
   logic            az_en_r;
   logic [15:0]     arg0_r;
   logic [15:0]     arg1_r;
   logic [7:0]      filter_r;
   logic [15:0]     fresh_r;
   logic [15:0]     az_level_r;
   logic [15:0]     az_first_r;
   logic [15:0]     az_period_r;
   logic [3:0]      cmd_r;
   logic            pend_r;
   logic            rej_r;
   logic            unk_r;
   logic [15:0]     filt_r;
   logic [15:0]     raw_r;
   logic signed [16:0] zero_r;
   logic            busy;
   op_mode_t        mode_r;
   meas_state_t     ms_r;

   assign acc   = cyc_i && stb_i && !ack_r;
   assign wr    = acc && we_i && sel_i[0];
   assign ack_o = ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) ack_r <= 1'b0;
      else ack_r <= acc;
   end

   // volatile settings restored on every reset [RULE18]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         az_en_r     <= 1'b0; // [RULE14]
         arg0_r      <= 16'h0000;
         arg1_r      <= 16'h0000;
         filter_r    <= `FILTER_RST;
         fresh_r     <= `FRESH_AIR_RST; // [RULE12]
         az_level_r  <= `FRESH_AIR_RST; // [RULE19]
         az_first_r  <= 16'h0000;
         az_period_r <= 16'h0000;
      end else if (wr) begin
         if (adr_i == `ADR_CTRL) begin
            az_en_r <= dat_i[`CTRL_AZ_EN]; // [RULE16]
         end else if (adr_i == `ADR_ARG0) begin
            arg0_r <= dat_i[15:0];
         end else if (adr_i == `ADR_ARG1) begin
            arg1_r <= dat_i[15:0];
         end else if (adr_i == `ADR_FILTER) begin
            filter_r <= dat_i[7:0];
         end else if (adr_i == `ADR_FRESH) begin
            fresh_r <= dat_i[15:0];
         end else if (adr_i == `ADR_AZ_LEVEL) begin
            az_level_r <= dat_i[15:0]; // [RULE19]
         end else if (adr_i == `ADR_AZ_FIRST) begin
            az_first_r <= dat_i[15:0]; // [RULE17]
         end else if (adr_i == `ADR_AZ_PERIOD) begin
            az_period_r <= dat_i[15:0]; // [RULE17]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) dat_o <= 32'h0000_0000;
      else if (acc && !we_i) begin
         if (adr_i == `ADR_CTRL) dat_o <= {30'h0, mode_r == MODE_POLL, az_en_r};
         else if (adr_i == `ADR_ARG0) dat_o <= {16'h0, arg0_r};
         else if (adr_i == `ADR_ARG1) dat_o <= {16'h0, arg1_r};
         else if (adr_i == `ADR_FILTER) dat_o <= {24'h0, filter_r};
         else if (adr_i == `ADR_FRESH) dat_o <= {16'h0, fresh_r};
         else if (adr_i == `ADR_AZ_LEVEL) dat_o <= {16'h0, az_level_r};
         else if (adr_i == `ADR_AZ_FIRST) dat_o <= {16'h0, az_first_r};
         else if (adr_i == `ADR_AZ_PERIOD) dat_o <= {16'h0, az_period_r};
         else if (adr_i == `ADR_STATUS)
            dat_o <= {26'h0, mode_r, unk_r, rej_r, pend_r, busy};
         else if (adr_i == `ADR_FILT_OUT) dat_o <= {16'h0, filt_r}; // [RULE6]
         else if (adr_i == `ADR_RAW_OUT) dat_o <= {16'h0, raw_r}; // [RULE6]
         else if (adr_i == `ADR_ZERO) dat_o <= {{15{zero_r[16]}}, zero_r};
         else dat_o <= 32'h0000_0000;
      end
   end

   // ****************************************
   // measurement timing
   // ****************************************
   logic [26:0] tick_r;
   logic        meas_done;
   logic        meas_start;

   assign busy       = (ms_r == MS_BUSY);
   assign meas_start = (mode_r != MODE_SLEEP) && (tick_r == 27'h0); // [RULE20]
   assign meas_done  = busy && (tick_r == 27'(MEAS_BUSY_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || mode_r == MODE_SLEEP) tick_r <= 27'h0;
      else if (tick_r == 27'(MEAS_CYC - 1)) tick_r <= 27'h0; // [RULE1]
      else tick_r <= tick_r + 27'h1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) ms_r <= MS_IDLE;
      else begin
         case (ms_r)
            MS_IDLE: if (meas_start) ms_r <= MS_BUSY;
            MS_BUSY: if (meas_done || mode_r == MODE_SLEEP) ms_r <= MS_IDLE;
            default: ms_r <= MS_IDLE;
         endcase
      end
   end

   // results keep updating in polling mode too [RULE4]
   logic [15:0] corr;
   logic signed [17:0] corr_s;
   assign corr_s = $signed({2'b00, sample_i}) - $signed({zero_r[16], zero_r});
   assign corr   = corr_s[17] ? 16'h0000 : corr_s[15:0];

   logic [7:0] shift;
   always_comb begin
      shift = 8'h0;
      if (filter_r >= 8'h40) shift = 8'h6;
      else if (filter_r >= 8'h20) shift = 8'h5;
      else if (filter_r >= 8'h10) shift = 8'h4;
      else if (filter_r >= 8'h08) shift = 8'h3;
      else if (filter_r >= 8'h02) shift = 8'h1;
   end

   logic signed [17:0] fdiff;
   assign fdiff = $signed({2'b00, corr}) - $signed({2'b00, filt_r});
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_r  <= 16'h0000;
         filt_r <= 16'h0000;
      end else if (meas_done) begin
         raw_r  <= corr; // [RULE6]
         // first-order low pass, strength set by filter [RULE6]
         filt_r <= 16'($signed({2'b00, filt_r}) + (fdiff >>> shift));
      end
   end

   // ****************************************
   // command handling
   // ****************************************
   logic cmd_take;
   logic go;
   logic zero_cmd;
   assign cmd_take = wr && (adr_i == `ADR_CMD);
   // hold while measuring in streaming [RULE2] [RULE23]
   assign go = pend_r && !(busy && mode_r == MODE_STREAM);
   assign zero_cmd = cmd_r == CMD_ZERO_KNOWN || cmd_r == CMD_ZERO_N2 ||
                     cmd_r == CMD_ZERO_AIR || cmd_r == CMD_FINE ||
                     cmd_r == CMD_AZ_FORCE;

   // a new command while one waits overwrites nothing: it is refused
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         cmd_r  <= 4'h0;
      end else if (cmd_take && !pend_r) begin
         pend_r <= 1'b1; // [RULE23]
         cmd_r  <= dat_i[3:0];
      end else if (go) pend_r <= 1'b0;
   end

   logic unk_now;
   logic rej_now;
   assign unk_now = go && (cmd_r == CMD_NONE || cmd_r > CMD_AZ_FORCE);
   assign rej_now = go && mode_r == MODE_SLEEP &&
                    (zero_cmd || cmd_r == CMD_READ_FILT ||
                     cmd_r == CMD_READ_RAW); // [RULE20]

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unk_r <= 1'b0;
         rej_r <= 1'b0;
      end else if (go) begin
         unk_r <= unk_now; // [RULE22]
         rej_r <= rej_now;
      end
   end

   // power-up mode from the stored choice, never sleep [RULE5] [RULE21]
   logic boot_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) boot_r <= 1'b1;
      else boot_r <= 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) mode_r <= MODE_STREAM; // [RULE1]
      else if (boot_r) mode_r <= nv_poll_i ? MODE_POLL : MODE_STREAM; // [RULE5]
      else if (go && cmd_r == CMD_SLEEP) mode_r <= MODE_SLEEP;
      else if (go && cmd_r == CMD_STREAM) mode_r <= MODE_STREAM;
      else if (go && cmd_r == CMD_POLL) mode_r <= MODE_POLL;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_wr_o   <= 1'b0;
         nv_poll_o <= 1'b0;
      end else begin
         nv_wr_o   <= go && (cmd_r == CMD_STREAM || cmd_r == CMD_POLL); // [RULE5]
         nv_poll_o <= (go && cmd_r == CMD_POLL) ? 1'b1 :
                      (go && cmd_r == CMD_STREAM) ? 1'b0 : nv_poll_o;
      end
   end

   // ****************************************
   // auto-zero timer, seconds
   // ****************************************
   logic [26:0] sec_r;
   logic [15:0] az_cnt_r;
   logic        az_first_done_r;
   logic        az_fire;
   logic        sec_tick;
   assign sec_tick = sec_r == 27'(AZ_TICK_CYC - 1);
   always_ff @(posedge clk_i) begin
      if (rst_i || sec_tick) sec_r <= 27'h0;
      else sec_r <= sec_r + 27'h1;
   end
   assign az_fire = az_en_r && sec_tick && mode_r != MODE_SLEEP &&
      ((!az_first_done_r && az_first_r != 16'h0 &&
        az_cnt_r + 16'h1 >= az_first_r) ||
       (az_first_done_r && az_period_r != 16'h0 &&
        az_cnt_r + 16'h1 >= az_period_r)); // [RULE14] [RULE17]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         az_cnt_r        <= 16'h0;
         az_first_done_r <= 1'b0;
      end else if (az_fire) begin
         az_cnt_r        <= 16'h0;
         az_first_done_r <= 1'b1;
      end else if (sec_tick && az_en_r) begin
         az_cnt_r <= az_cnt_r + 16'h1;
         if (az_first_r == 16'h0) az_first_done_r <= 1'b1;
      end
   end

   // ****************************************
   // zero point: each event except fine adjust replaces it; fine adjust shifts it [RULE8]
   // ****************************************
   logic do_cmd;
   assign do_cmd = go && !rej_now;
   always_ff @(posedge clk_i) begin
      if (rst_i) zero_r <= 17'sh0;
      else if (do_cmd && cmd_r == CMD_ZERO_KNOWN)
         zero_r <= $signed({1'b0, sample_i})
                   - $signed({1'b0, arg0_r}); // [RULE10]
      else if (do_cmd && cmd_r == CMD_ZERO_N2)
         zero_r <= $signed({1'b0, sample_i}); // [RULE11]
      else if (do_cmd && cmd_r == CMD_ZERO_AIR)
         zero_r <= $signed({1'b0, sample_i}) - $signed({1'b0, fresh_r}); // [RULE12]
      else if (do_cmd && cmd_r == CMD_FINE)
         zero_r <= zero_r + $signed({1'b0, arg1_r})
                   - $signed({1'b0, arg0_r}); // [RULE13]
      else if ((do_cmd && cmd_r == CMD_AZ_FORCE) || az_fire)
         zero_r <= $signed({1'b0, sample_i})
                   - $signed({1'b0, az_level_r}); // [RULE15] [RULE16]
   end

   // ****************************************
   // reports
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         report_o     <= 1'b0;
         report_dat_o <= 16'h0000;
         unknown_o    <= 1'b0;
      end else begin
         unknown_o <= unk_now; // [RULE22]
         if (meas_done && mode_r == MODE_STREAM) begin
            report_o     <= 1'b1; // [RULE1]
            report_dat_o <= corr;
         end else if (do_cmd && mode_r != MODE_SLEEP &&
                      (cmd_r == CMD_READ_FILT || cmd_r == CMD_READ_RAW)) begin
            report_o     <= 1'b1; // [RULE3]
            report_dat_o <= (cmd_r == CMD_READ_FILT) ? filt_r : raw_r;
         end else report_o <= 1'b0;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_poll_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_r == MODE_POLL && !go) |=> !report_o) // [RULE3]
      else $error("report without request in polling");
   a_sleep_no_meas: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_r == MODE_SLEEP |-> !meas_start) // [RULE20]
      else $error("measurement started in sleep");
   a_hold_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      (pend_r && busy && mode_r == MODE_STREAM) |=> pend_r) // [RULE2]
      else $error("command run during measurement");
   a_pend_runs: assert property (@(posedge clk_i) disable iff (rst_i)
      (pend_r && !busy) |=> !pend_r) // [RULE23]
      else $error("pending command not run");
   a_az_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (!az_en_r && !do_cmd) |=> $stable(zero_r)) // [RULE14]
      else $error("zero point moved with auto-zero off");
   a_not_sleep_boot: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(boot_r) |-> mode_r != MODE_SLEEP) // [RULE21]
      else $error("sleep after power-up");
   a_n2_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (do_cmd && cmd_r == CMD_ZERO_N2) |=> zero_r == $past(sample_i)) // [RULE11]
      else $error("nitrogen zero wrong");
   a_unk_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      unk_now |=> unknown_o && unk_r) // [RULE22]
      else $error("unknown command not flagged");
   c_stream: cover property (@(posedge clk_i) report_o && mode_r == MODE_STREAM);
   c_poll: cover property (@(posedge clk_i) report_o && mode_r == MODE_POLL);
   c_az: cover property (@(posedge clk_i) az_fire);
endmodule

// ==== rtl/gas_zero_params.svh ====
// constants for the gas sensor mode and zero control block
`ifndef GAS_ZERO_PARAMS_SVH
`define GAS_ZERO_PARAMS_SVH
`define CLK_HZ            125000000
`define REPORT_RATE_HZ    20
`define MEAS_CYC          (`CLK_HZ / `REPORT_RATE_HZ)
`define MEAS_BUSY_MS      10
`define MEAS_BUSY_CYC     ((`CLK_HZ / 1000) * `MEAS_BUSY_MS)
`define FRESH_AIR_RST     16'h0190
`define FILTER_RST        8'h10
`define ADR_CTRL          8'h00
`define ADR_CMD           8'h04
`define ADR_ARG0          8'h08
`define ADR_ARG1          8'h0C
`define ADR_FILTER        8'h10
`define ADR_FRESH         8'h14
`define ADR_AZ_LEVEL      8'h18
`define ADR_AZ_FIRST      8'h1C
`define ADR_AZ_PERIOD     8'h20
`define ADR_STATUS        8'h24
`define ADR_FILT_OUT      8'h28
`define ADR_RAW_OUT       8'h2C
`define ADR_ZERO          8'h30
`define CTRL_AZ_EN        0
`define STAT_BUSY         0
`define STAT_PEND         1
`define STAT_REJ          2
`define STAT_UNK          3
`endif

// ==== rtl/gas_zero_pkg.sv ====
// types for the gas sensor mode and zero control block
package gas_zero_pkg;
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_STREAM,
      MODE_POLL
   } op_mode_t;
   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_SLEEP,
      CMD_STREAM,
      CMD_POLL,
      CMD_READ_FILT,
      CMD_READ_RAW,
      CMD_ZERO_KNOWN,
      CMD_ZERO_N2,
      CMD_ZERO_AIR,
      CMD_FINE,
      CMD_AZ_FORCE
   } cmd_t;
   typedef enum logic [1:0] {
      MS_IDLE,
      MS_BUSY
   } meas_state_t;
endpackage

// ==== verif/gas_nv_store.sv ====
// non-volatile mode store model facing the sensor control block
`timescale 1ns/1ps
module gas_nv_store (
   input  wire logic clk_i,
   input  wire logic nv_wr_i,
   input  wire logic nv_poll_i,
   output logic      nv_poll_o
);
   // ***********************************************
   // stored mode bit
   // ***********************************************
   // no reset input: the bit must outlive a power cycle of the block
   logic poll_r = 1'b0;
   always_ff @(posedge clk_i) begin
      if (nv_wr_i) begin
         poll_r <= nv_poll_i;
      end
   end
   assign nv_poll_o = poll_r;
endmodule

// ==== verif/gas_zero_ctrl_bench.sv ====
// bus-level self-checking bench of the gas sensor mode and zero control
`timescale 1ns/1ps
`include "gas_zero_params.svh"
module gas_zero_ctrl_bench;
   // ***********************************************
   // signals and instances
   // ***********************************************
   logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [3:0]  sel_i = 4'hF;
   logic [15:0] sample_i = 16'h0500;
   logic        ack_o, nv_poll_i, nv_poll_o, nv_wr_o, report_o, unknown_o;
   logic [15:0] report_dat_o;
   logic [15:0] last_rep = 16'h0000;
   int          num_errors = 0, num_checks = 0, reps = 0, unks = 0, n, k;
   gas_zero_ctrl #(.MEAS_CYC(200), .MEAS_BUSY_CYC(20), .AZ_TICK_CYC(50))
      gas_zero_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sample_i(sample_i),
      .nv_poll_i(nv_poll_i), .nv_poll_o(nv_poll_o), .nv_wr_o(nv_wr_o),
      .report_o(report_o), .report_dat_o(report_dat_o),
      .unknown_o(unknown_o));
   gas_nv_store gas_nv_store_inst (.clk_i(clk_i), .nv_wr_i(nv_wr_o),
      .nv_poll_i(nv_poll_o), .nv_poll_o(nv_poll_i));
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (report_o === 1'b1) begin
         reps++;
         last_rep = report_dat_o;
      end
      if (unknown_o === 1'b1) unks++;
   end
   // ***********************************************
   // tasks
   // ***********************************************
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // classic cycle: hold everything until ack is sampled high
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1; stb_i <= 1;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      @(posedge clk_i);
   endtask
   task rchk(input string what, input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      check(what, rd, e);
   endtask
   // long enough for the busy window plus two full measurements
   task cmd(input logic [31:0] c);
      wb(`ADR_CMD, 1'b1, c);
      repeat (450) @(posedge clk_i);
   endtask
   task do_reset();
      rst_i <= 1;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      repeat (50000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end
   // ***********************************************
   // tests
   // ***********************************************
   initial begin
      do_reset();
      rchk("filter", `ADR_FILTER, 32'h00000010);
      rchk("fresh", `ADR_FRESH, 32'h00000190);
      rchk("az_level", `ADR_AZ_LEVEL, 32'h00000190);
      rchk("ctrl", `ADR_CTRL, 32'h00000000);
      rchk("unmapped", 8'h40, 32'h00000000);
      wb(`ADR_STATUS, 1'b0, 32'h0);
      check("mode", rd[5:4], 32'h1);
      n = 0;
      do begin @(posedge clk_i); n++; end while (report_o !== 1'b1 && n < 900);
      n = 0;
      do begin @(posedge clk_i); n++; end while (report_o !== 1'b1 && n < 900);
      check("interval", n, 32'd200);
      @(posedge clk_i);
      check("rep_dat", last_rep, 32'h0500);
      $display("test defaults done");
      wb(`ADR_AZ_LEVEL, 1'b1, 32'h0010);
      wb(`ADR_AZ_PERIOD, 1'b1, 32'h1);
      wb(`ADR_ZERO, 1'b0, 32'h0);
      k = rd;
      repeat (450) @(posedge clk_i);
      rchk("az_off", `ADR_ZERO, k);
      wb(`ADR_FILTER, 1'b1, 32'h20);
      cmd(32'h7);
      rchk("n2", `ADR_RAW_OUT, 32'h0000);
      wb(`ADR_ARG0, 1'b1, 32'h0100);
      cmd(32'h6);
      rchk("known", `ADR_RAW_OUT, 32'h0100);
      wb(`ADR_FRESH, 1'b1, 32'h0064);
      cmd(32'h8);
      rchk("fresh_z", `ADR_RAW_OUT, 32'h0064);
      wb(`ADR_ARG0, 1'b1, 32'h00C8);
      wb(`ADR_ARG1, 1'b1, 32'h0064);
      cmd(32'h9);
      rchk("fine", `ADR_RAW_OUT, 32'h00C8);
      wb(`ADR_AZ_LEVEL, 1'b1, 32'h0032);
      cmd(32'hA);
      rchk("force", `ADR_RAW_OUT, 32'h0032);
      rchk("fresh_kept", `ADR_FRESH, 32'h0064);
      sample_i <= 16'h0600;
      wb(`ADR_CTRL, 1'b1, 32'h1);
      repeat (450) @(posedge clk_i);
      rchk("periodic", `ADR_RAW_OUT, 32'h0032);
      wb(`ADR_CTRL, 1'b1, 32'h0);
      wb(`ADR_AZ_PERIOD, 1'b1, 32'h0);
      $display("test zero done");
      // unknown codes at many phases of the measurement cycle
      k = unks;
      for (int i = 0; i < 8; i++) begin
         wb(`ADR_CMD, 1'b1, 32'hF);
         n = 0;
         // the pulse may come before the write task returns: count it
         while (unks == k + i && n < 300) begin
            @(posedge clk_i);
            n++;
         end
         check("defer", n <= 24, 1'b1);
         repeat (13 + i * 7) @(posedge clk_i);
      end
      check("unknown", unks - k, 32'd8);
      $display("test unknown done");
      cmd(32'h3);
      check("nv", nv_poll_i, 1'b1);
      k = reps;
      sample_i <= 16'h0700;
      repeat (600) @(posedge clk_i);
      check("quiet", reps - k, 32'd0);
      rchk("bg", `ADR_RAW_OUT, 32'h0132);
      cmd(32'h4);
      check("polled", reps - k, 32'd1);
      cmd(32'h5);
      check("polled_raw", reps - k, 32'd2);
      check("raw_dat", last_rep, 32'h0132);
      $display("test poll done");
      cmd(32'h1);
      wb(`ADR_ZERO, 1'b0, 32'h0);
      n = rd;
      k = reps;
      for (int c = 4; c <= 10; c++) cmd(c);
      rchk("sleep_zero", `ADR_ZERO, n);
      check("sleep_rep", reps - k, 32'd0);
      rchk("sleep_stat", `ADR_STATUS, 32'h00000004);
      $display("test sleep done");
      wb(`ADR_AZ_LEVEL, 1'b1, 32'h0055);
      wb(`ADR_CTRL, 1'b1, 32'h1);
      do_reset();
      wb(`ADR_STATUS, 1'b0, 32'h0);
      check("resume", rd[5:4], 32'h2);
      rchk("az_en", `ADR_CTRL, 32'h00000002);
      rchk("az_lvl", `ADR_AZ_LEVEL, 32'h00000190);
      $display("test power cycle done");
      stop_test();
   end
endmodule
